// *** cmd_handler.v ***
// Purpose: executes serial control commands 51..56 posted over APB
// Assumes: pclk 100 MHz; activity_pin asynchronous; tx_ready same clock
// Notes:
// Notes on behaviour
// - framing command id 51, one 32-bit argument, legal values 1 and 2.
// - text form: 1 selects text, 2 binary; no value reports current framing.
// - binary framing command replies with last executed framing selection.
// - generator id 52, three words: channel, group 1/3/7, type, amplitude, freq.
// - generator type 0 off, 1 pink, 2 white, 3 tone.
// - amplitude -60 to +20 dB, omitted when type is 0.
// - tone frequency 20 to 20000 Hz; noise types carry frequency zero.
// - generator command replies with most recent activation, same layout.
// - string command id 53, value 0..7, sends that stored string out.
// - string reply is index; no value reports last executed, sends nothing.
// - idle command id 54, 1..15 minutes without activity returns title screen.
// - text idle value 0 disables return; no value reports current setting.
// - binary idle command replies with last executed timeout selection.
// - unit code id 55, read-only, returns 32-bit identifier.
// - release query id 56, read-only: major, minor, release in top bytes.
// - text release query returns major.minor.release separated by periods.
// - each text setting command answers with the updated setting.
`timescale 1ns/1ns
`default_nettype none
`include "cmd_handler_map.vh"
module cmd_handler #(
   parameter STR_LEN = 16, // bytes per stored string
   parameter STR_AW = 7, // string memory address bits
   parameter [31:0] CYCLES_PER_SEC = `NS_PER_SEC / `CLK_PERIOD_NS,
   parameter [31:0] UNIT_CODE = 32'h5A3C0001, // arbitrary value
   parameter [7:0] REL_MAJOR = 8'h01, // arbitrary value
   parameter [7:0] REL_MINOR = 8'h00, // arbitrary value
   parameter [7:0] REL_ID = 8'h00 // arbitrary value
) (
   input wire pclk, // clock
   input wire presetn, // async reset, active low
   input wire ce, // clock enable
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [7:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire activity_pin, // user activity, async
   output reg title_return, // pulse: back to title screen
   output reg binary_framing, // 1: binary framing selected
   output reg [7:0] src_channel, // test source channel
   output reg [7:0] src_group, // test source group
   output reg [15:0] src_type, // test source type
   output reg [31:0] src_amplitude, // float dB
   output reg [31:0] src_frequency, // float Hz
   output reg src_update, // pulse: new activation
   output wire [7:0] tx_data, // string byte out
   output wire tx_valid, // string byte valid
   input wire tx_ready // serial port takes byte
);
   localparam S_IDLE = 3'b001;
   localparam S_READ = 3'b010;
   localparam S_SEND = 3'b100;

   reg [2:0] state_reg;
   reg [7:0] cnt_reg;
   reg [2:0] str_idx_reg;
   reg [1:0] framing_reg;
   reg [3:0] idle_reg;
   reg [2:0] last_str_reg;
   reg [31:0] arg0_reg;
   reg [31:0] arg1_reg;
   reg [31:0] arg2_reg;
   reg [7:0] rsp_id_reg;
   reg [31:0] rsp0_reg;
   reg [31:0] rsp1_reg;
   reg [31:0] rsp2_reg;
   reg done_reg;
   reg reject_reg;
   reg unknown_reg;
   reg [STR_AW-1:0] str_waddr_reg;
   reg act_meta_reg;
   reg act_sync_reg;
   reg [31:0] tick_reg;
   reg [5:0] sec_reg;
   reg [3:0] min_reg;

   wire [7:0] str_rdata;
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire start = wr & (paddr == `OFS_CMD) & state_reg[0];
   wire [7:0] cmd_id = pwdata[`CMD_ID_MSB:0];
   wire text_form = pwdata[`CMD_TEXT_BIT];
   wire omit = text_form & pwdata[`CMD_OMIT_BIT];
   wire busy = ~state_reg[0];

   // positive floats compare as unsigned words
   function flt_le;
      input [31:0] a;
      input [31:0] b;
      begin
         flt_le = (a <= b);
      end
   endfunction

   function amp_ok;
      input [31:0] a;
      begin
         if (a[31]) begin
            amp_ok = flt_le({1'b0, a[30:0]}, `FLT_60);
         end else begin
            amp_ok = flt_le(a, `FLT_20);
         end
      end
   endfunction

   wire [7:0] g_grp = arg0_reg[23:16];
   wire [15:0] g_type = arg0_reg[15:0];
   wire grp_ok = (g_grp == `GROUP_INPUT) | (g_grp == `GROUP_MIC) |
      (g_grp == `GROUP_LINE);
   wire type_ok = (g_type <= `SRC_TYPE_MAX);
   wire freq_ok = (g_type == `SRC_TYPE_TONE) ?
      (flt_le(`FLT_20, arg2_reg) & flt_le(arg2_reg, `FLT_20K)) :
      (arg2_reg[30:0] == 31'h0);
   wire gen_ok = grp_ok & type_ok &
      ((g_type == 16'h0000) | (amp_ok(arg1_reg) & freq_ok));
   wire [31:0] rel_word = {REL_MAJOR, REL_MINOR, REL_ID, 8'h00};

   wire str_rd_en = state_reg[1];
   wire [STR_AW-1:0] str_raddr =
      str_idx_reg * STR_LEN[STR_AW-1:0] + cnt_reg[STR_AW-1:0];
   wire str_wr = wr & (paddr == `OFS_STR_DATA);

   string_store #(.AW(STR_AW)) u_store (
      .pclk(pclk),
      .ce(ce),
      .wr_en(str_wr),
      .wr_addr(str_waddr_reg),
      .wr_data(pwdata[7:0]),
      .rd_en(str_rd_en),
      .rd_addr(str_raddr),
      .rd_data(str_rdata)
   );

   // a zero byte ends a string early
   assign tx_valid = state_reg[2] & (str_rdata != 8'h00);
   assign tx_data = str_rdata;

   // apb: one wait state so read data leaves a flip-flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel & penable & ~pready) begin
            case (paddr)
               `OFS_CMD: prdata <= {24'h000000, rsp_id_reg};
               `OFS_ARG0: prdata <= arg0_reg;
               `OFS_ARG1: prdata <= arg1_reg;
               `OFS_ARG2: prdata <= arg2_reg;
               `OFS_STATUS: prdata <= {28'h0000000, unknown_reg,
                  reject_reg, done_reg, busy};
               `OFS_RSP_ID: prdata <= {24'h000000, rsp_id_reg};
               `OFS_RSP0: prdata <= rsp0_reg;
               `OFS_RSP1: prdata <= rsp1_reg;
               `OFS_RSP2: prdata <= rsp2_reg;
               `OFS_STR_ADDR: prdata <= {{(32-STR_AW){1'b0}},
                  str_waddr_reg};
               `OFS_STR_DATA: prdata <= 32'h00000000;
               `OFS_SETTINGS: prdata <= {20'h00000, last_str_reg, 1'b0,
                  idle_reg, 2'h0, framing_reg};
               default: pslverr <= 1'b1;
            endcase
            if (pwrite) begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   // argument and string address registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg0_reg <= 32'h00000000;
         arg1_reg <= 32'h00000000;
         arg2_reg <= 32'h00000000;
         str_waddr_reg <= {STR_AW{1'b0}};
      end else if (ce) begin
         if (wr & (paddr == `OFS_ARG0)) begin
            arg0_reg <= pwdata;
         end
         if (wr & (paddr == `OFS_ARG1)) begin
            arg1_reg <= pwdata;
         end
         if (wr & (paddr == `OFS_ARG2)) begin
            arg2_reg <= pwdata;
         end
         if (wr & (paddr == `OFS_STR_ADDR)) begin
            str_waddr_reg <= pwdata[STR_AW-1:0];
         end else if (str_wr) begin
            str_waddr_reg <= str_waddr_reg + 1'b1;
         end
      end
   end

   // command execution and settings
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         framing_reg <= `RST_FRAMING;
         idle_reg <= `RST_IDLE;
         last_str_reg <= 3'h0;
         binary_framing <= 1'b0;
         src_channel <= 8'h00;
         src_group <= 8'h00;
         src_type <= 16'h0000;
         src_amplitude <= 32'h00000000;
         src_frequency <= 32'h00000000;
         src_update <= 1'b0;
         rsp_id_reg <= 8'h00;
         rsp0_reg <= 32'h00000000;
         rsp1_reg <= 32'h00000000;
         rsp2_reg <= 32'h00000000;
         done_reg <= 1'b0;
         reject_reg <= 1'b0;
         unknown_reg <= 1'b0;
         str_idx_reg <= 3'h0;
      end else if (ce) begin
         src_update <= 1'b0;
         // set wins over a clear in the same cycle
         if (wr & (paddr == `OFS_STATUS)) begin
            if (pwdata[`ST_DONE_BIT]) begin
               done_reg <= 1'b0;
            end
            if (pwdata[`ST_REJECT_BIT]) begin
               reject_reg <= 1'b0;
            end
            if (pwdata[`ST_UNKNOWN_BIT]) begin
               unknown_reg <= 1'b0;
            end
         end
         if (start) begin
            done_reg <= 1'b1;
            rsp_id_reg <= cmd_id;
            rsp1_reg <= 32'h00000000;
            rsp2_reg <= 32'h00000000;
            case (cmd_id)
               `ID_FRAMING: begin
                  if (!omit & ((arg0_reg == `FRAMING_TEXT) |
                        (arg0_reg == `FRAMING_BINARY))) begin
                     framing_reg <= arg0_reg[1:0];
                     binary_framing <= arg0_reg[1];
                     rsp0_reg <= arg0_reg;
                  end else begin
                     if (!omit) begin
                        reject_reg <= 1'b1;
                     end
                     rsp0_reg <= {30'h0, framing_reg};
                  end
               end
               `ID_TEST_SRC: begin
                  if (!omit & gen_ok) begin
                     src_channel <= arg0_reg[31:24];
                     src_group <= g_grp;
                     src_type <= g_type;
                     src_amplitude <= (g_type == 16'h0000) ?
                        32'h00000000 : arg1_reg;
                     src_frequency <= (g_type == `SRC_TYPE_TONE) ?
                        arg2_reg : 32'h00000000;
                     src_update <= 1'b1;
                     rsp0_reg <= arg0_reg;
                     rsp1_reg <= (g_type == 16'h0000) ?
                        32'h00000000 : arg1_reg;
                     rsp2_reg <= (g_type == `SRC_TYPE_TONE) ?
                        arg2_reg : 32'h00000000;
                  end else begin
                     if (!omit) begin
                        reject_reg <= 1'b1;
                     end
                     rsp0_reg <= {src_channel, src_group, src_type};
                     rsp1_reg <= src_amplitude;
                     rsp2_reg <= src_frequency;
                  end
               end
               `ID_STRING: begin
                  if (!omit & (arg0_reg <= `STRING_MAX)) begin
                     str_idx_reg <= arg0_reg[2:0];
                     last_str_reg <= arg0_reg[2:0];
                     rsp0_reg <= arg0_reg;
                  end else begin
                     if (!omit) begin
                        reject_reg <= 1'b1;
                     end
                     rsp0_reg <= {29'h0, last_str_reg};
                  end
               end
               `ID_IDLE: begin
                  if (!omit & (arg0_reg <= `IDLE_MAX) &
                        (text_form | (arg0_reg != 32'h0))) begin
                     idle_reg <= arg0_reg[3:0];
                     rsp0_reg <= arg0_reg;
                  end else begin
                     if (!omit) begin
                        reject_reg <= 1'b1;
                     end
                     rsp0_reg <= {28'h0, idle_reg};
                  end
               end
               `ID_UNIT_CODE: rsp0_reg <= UNIT_CODE;
               `ID_RELEASE: begin
                  rsp0_reg <= rel_word;
                  if (text_form) begin
                     rsp1_reg <= {REL_MAJOR, `ASCII_PERIOD, REL_MINOR,
                        `ASCII_PERIOD};
                     rsp2_reg <= {REL_ID, 24'h000000};
                  end
               end
               default: begin
                  unknown_reg <= 1'b1;
                  rsp0_reg <= 32'h00000000;
               end
            endcase
         end
      end
   end

   wire send_go = start & (cmd_id == `ID_STRING) & !omit &
      (arg0_reg <= `STRING_MAX);

   // string transmit sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         cnt_reg <= 8'h00;
      end else if (ce) begin
         case (state_reg)
            S_IDLE: begin
               cnt_reg <= 8'h00;
               if (send_go) begin
                  state_reg <= S_READ;
               end
            end
            S_READ: state_reg <= S_SEND;
            S_SEND: begin
               if (str_rdata == 8'h00) begin
                  state_reg <= S_IDLE;
               end else if (tx_ready) begin
                  if (cnt_reg == STR_LEN[7:0] - 8'h01) begin
                     state_reg <= S_IDLE;
                  end else begin
                     cnt_reg <= cnt_reg + 8'h01;
                     state_reg <= S_READ;
                  end
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // activity pin comes from outside the clock domain
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_meta_reg <= 1'b0;
         act_sync_reg <= 1'b0;
      end else if (ce) begin
         act_meta_reg <= activity_pin;
         act_sync_reg <= act_meta_reg;
      end
   end

   // any pin activity or command accepted in S_IDLE restarts the idle count
   wire activity = act_sync_reg | start;
   wire sec_tick = (tick_reg == CYCLES_PER_SEC - 32'h1);
   wire min_tick = sec_tick & (sec_reg == `SEC_PER_MIN - 6'd1);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_reg <= 32'h00000000;
         sec_reg <= 6'd0;
         min_reg <= 4'h0;
         title_return <= 1'b0;
      end else if (ce) begin
         title_return <= 1'b0;
         if (activity | (idle_reg == 4'h0)) begin
            tick_reg <= 32'h00000000;
            sec_reg <= 6'd0;
            min_reg <= 4'h0;
         end else if (min_reg != idle_reg) begin
            tick_reg <= sec_tick ? 32'h00000000 : tick_reg + 32'h1;
            if (sec_tick) begin
               sec_reg <= min_tick ? 6'd0 : sec_reg + 6'd1;
            end
            if (min_tick) begin
               min_reg <= min_reg + 4'h1;
               // fires once, then waits for new activity
               if (min_reg + 4'h1 == idle_reg) begin
                  title_return <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** cmd_handler_chk.sv ***
// Purpose: port-level checks on the command handler
// Assumes: ce held high, one clock domain
// Notes:   bound to every cmd_handler instance
`timescale 1ns/1ns
`default_nettype none
module cmd_handler_chk (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic title_return, // title screen pulse
   input wire logic binary_framing, // framing level
   input wire logic src_update, // activation pulse
   input wire logic [7:0] tx_data, // string byte
   input wire logic tx_valid, // byte valid
   input wire logic tx_ready // byte taken
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire cmd_wr = psel && penable && pready && pwrite && paddr == 8'h00;
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable && !pready; endsequence
   chk_one_wait: assert property (setup_s ##1 access_s |=> pready)
      else $error("pready missing in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("pslverr without completing transfer");
   chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 0)
      else $error("prdata nonzero outside read completion");
   chk_framing_cause: assert property (
      !$stable(binary_framing) |-> $past(cmd_wr && pwdata[7:0] == 8'h33))
      else $error("framing changed without framing command");
   chk_src_cause: assert property (
      src_update |-> $past(cmd_wr && pwdata[7:0] == 8'h34))
      else $error("src_update without generator command");
   chk_src_pulse: assert property (src_update |=> !src_update)
      else $error("src_update longer than one cycle");
   chk_title_pulse: assert property (title_return |=> !title_return)
      else $error("title_return longer than one cycle");
   chk_tx_hold: assert property (
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte dropped or changed before taken");
   chk_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("no idle cycle after accepted byte");
endmodule
bind cmd_handler cmd_handler_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .title_return(title_return), .binary_framing(binary_framing),
   .src_update(src_update), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready));
`default_nettype wire

// *** cmd_handler_map.vh ***
// Purpose: offsets, fields, command codes and reset values of the
//          serial control command handler
// Assumes: 32-bit APB, one register per aligned word
// Notes:   included by the handler and the testbench
`ifndef CMD_HANDLER_MAP_VH
`define CMD_HANDLER_MAP_VH

// register byte offsets
`define OFS_CMD 8'h00
`define OFS_ARG0 8'h04
`define OFS_ARG1 8'h08
`define OFS_ARG2 8'h0C
`define OFS_STATUS 8'h10
`define OFS_RSP_ID 8'h14
`define OFS_RSP0 8'h18
`define OFS_RSP1 8'h1C
`define OFS_RSP2 8'h20
`define OFS_STR_ADDR 8'h24
`define OFS_STR_DATA 8'h28
`define OFS_SETTINGS 8'h2C

// command register fields
`define CMD_ID_MSB 7
`define CMD_TEXT_BIT 8
`define CMD_OMIT_BIT 9

// status register fields
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REJECT_BIT 2
`define ST_UNKNOWN_BIT 3

// command identifiers
`define ID_FRAMING 8'h33
`define ID_TEST_SRC 8'h34
`define ID_STRING 8'h35
`define ID_IDLE 8'h36
`define ID_UNIT_CODE 8'h37
`define ID_RELEASE 8'h38

// argument ranges
`define FRAMING_TEXT 32'h00000001
`define FRAMING_BINARY 32'h00000002
`define GROUP_INPUT 8'h01
`define GROUP_MIC 8'h03
`define GROUP_LINE 8'h07
`define SRC_TYPE_MAX 16'h0003
`define SRC_TYPE_TONE 16'h0003
`define STRING_MAX 32'h00000007
`define IDLE_MAX 32'h0000000F
// ieee single: 20.0, 60.0 magnitude, 20000.0
`define FLT_20 32'h41A00000
`define FLT_60 32'h42700000
`define FLT_20K 32'h469C4000
`define ASCII_PERIOD 8'h2E

// reset values
`define RST_FRAMING 2'h1
`define RST_IDLE 4'h0

// timing
`define CLK_PERIOD_NS 10
`define NS_PER_SEC 1000000000
`define SEC_PER_MIN 6'd60

`endif

// *** serial_sink.sv ***
// Purpose: serial port receiver beyond the string transmitter
// Assumes: same clock as the handler
// Notes:   slow mode takes a byte about one cycle in four
`timescale 1ns/1ns
`default_nettype none
module serial_sink (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic slow, // 1: stall at random
   output var logic tx_ready // byte taken at this edge
);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= slow ? ($urandom_range(0, 3) == 0) : 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** string_store.v ***
// Purpose: byte memory holding the stored serial strings
// Assumes: single clock, one write and one read port
// Notes:   read data is registered, one cycle after rd_en
`timescale 1ns/1ns
`default_nettype none
module string_store #(
   parameter AW = 7
) (
   input wire pclk, // clock
   input wire ce, // clock enable
   input wire wr_en, // write strobe
   input wire [AW-1:0] wr_addr, // write address
   input wire [7:0] wr_data, // write byte
   input wire rd_en, // read strobe
   input wire [AW-1:0] rd_addr, // read address
   output reg [7:0] rd_data // registered read byte
);
   reg [7:0] mem [0:(1<<AW)-1];

   // no reset: contents are loaded by software before use
   always @(posedge pclk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         if (rd_en) begin
            rd_data <= mem[rd_addr];
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench for the command handler
// Assumes: apb master here, serial receiver in serial_sink
// Notes:   one second is 10 cycles, so a minute is 600
`timescale 1ns/1ns
`default_nettype none
`include "cmd_handler_map.vh"
module testbench;
   logic pclk, presetn, psel, penable, pwrite, activity_pin, slow;
   logic [7:0] paddr, ch;
   logic [31:0] pwdata, rd, g0, g1, g2;
   wire [31:0] prdata, src_amplitude, src_frequency;
   wire pready, pslverr, title_return, binary_framing, src_update;
   wire tx_valid, tx_ready;
   wire [7:0] src_channel, src_group, tx_data;
   wire [15:0] src_type;
   int mismatches = 0, checks = 0, upd = 0;
   logic [65:0] exp_q[$];
   logic [7:0] byte_q[$];
   logic [7:0] mem [0:127];
   localparam [31:0] UCODE = 32'h13572468; // arbitrary value
   localparam [7:0] MAJ = 8'h02, MIN = 8'h07, REL = 8'h05; // arbitrary
   cmd_handler #(.CYCLES_PER_SEC(32'd10), .UNIT_CODE(UCODE),
      .REL_MAJOR(MAJ), .REL_MINOR(MIN), .REL_ID(REL)) DUT (.pclk(pclk),
      .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .activity_pin(activity_pin),
      .title_return(title_return), .binary_framing(binary_framing),
      .src_channel(src_channel), .src_group(src_group),
      .src_type(src_type), .src_amplitude(src_amplitude),
      .src_frequency(src_frequency), .src_update(src_update),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
   serial_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow),
      .tx_ready(tx_ready));
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   task check(input string what, input logic [32:0] exp, got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   always @(posedge pclk) begin
      logic [65:0] e;
      if (psel && penable && pready === 1'b1) begin
         e = exp_q.pop_front();
         check("apb", e[32:0] & e[65:33], {pslverr, prdata} & e[65:33]);
      end
      if (tx_valid === 1'b1 && tx_ready)
         check("tx byte", byte_q.pop_front(), tx_data);
      if (src_update === 1'b1) upd++;
   end
   // call just after a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e, m);
      int n;
      exp_q.push_back({m, e});
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) check("pready", 1, 0);
      rd = prdata;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d, 0, '1);
   endtask
   task rdm(input logic [7:0] a, input logic [31:0] e, m);
      apb(0, a, 0, e, {1'b1, m});
   endtask
   task do_cmd(input logic [31:0] c, a0, input logic rej,
      input logic [31:0] rsp);
      wr(`OFS_STATUS, 32'hE);
      wr(`OFS_ARG0, a0);
      wr(`OFS_CMD, c);
      rdm(`OFS_STATUS, {29'h0, rej, 2'h0}, (rej === 1'bx) ? 0 : 4);
      rdm(`OFS_RSP0, rsp, '1);
   endtask
   task frame(input logic [31:0] c, v, input logic rej, input int fr);
      do_cmd(c, v, rej, fr);
      check("binary_framing", fr == 2, binary_framing);
      rdm(`OFS_SETTINGS, fr, 3);
   endtask
   task gen(input logic [31:0] w0, w1, w2, input logic rej);
      wr(`OFS_ARG1, w1);
      wr(`OFS_ARG2, w2);
      if (!rej) begin
         g0 = w0;
         g1 = (w0[15:0] == 0) ? 0 : w1;
         g2 = (w0[15:0] == 3) ? w2 : 0;
      end
      do_cmd(32'h34, w0, rej, g0);
      rdm(`OFS_RSP1, g1, '1);
      rdm(`OFS_RSP2, g2, '1);
      check("src_type", g0[15:0], src_type);
      check("src_group", g0[23:16], src_group);
      check("src_channel", g0[31:24], src_channel);
      if (g0[15:0] != 0) check("src_amplitude", g1, src_amplitude);
      if (g0[15:0] != 0) check("src_frequency", g2, src_frequency);
   endtask
   task wait_title(output int n);
      n = 0;
      while (title_return !== 1'b1 && n < 700) begin @(posedge pclk); n++; end
   endtask
   task run_str(input int k, input logic s);
      int i;
      slow <= s;
      for (i = 0; i < 16 && mem[k * 16 + i] != 0; i++)
         byte_q.push_back(mem[k * 16 + i]);
      do_cmd(32'h35, k, 0, k);
      for (i = 0; i < 60 && (byte_q.size() > 0 || rd[0] !== 1'b0); i++)
         apb(0, `OFS_STATUS, 0, 0, 0);
      check("string sent", 0, byte_q.size());
      rdm(`OFS_SETTINGS, k << 9, 32'hE00);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge pclk);
      check("run length", 1, 0);
      print_verdict;
   end
   initial begin
      int i, k, n, len;
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; activity_pin = 0; slow = 0; rd = 0;
      void'($urandom(91482));
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      check("binary_framing", 0, binary_framing);
      rdm(`OFS_SETTINGS, 32'h1, '1);
      apb(0, 8'h30, 0, {1'b1, 32'h0}, '1);
      apb(1, 8'h30, 32'hFFFF, {1'b1, 32'h0}, '1);
      $display("test reset and map done");
      frame(32'h033, 2, 0, 2);
      frame(32'h033, 3, 1, 2);
      frame(32'h033, 0, 1, 2);
      frame(32'h133, 1, 0, 1);
      frame(32'h333, 2, 0, 1);
      frame(32'h133, 2, 0, 2);
      $display("test framing done");
      for (i = 0; i < 4; i++) begin
         ch = $urandom_range(1, 12);
         gen({ch, (i == 2) ? 8'h07 : (i[0] ? 8'h03 : 8'h01), i[15:0]},
            (i == 0) ? $urandom : (i[0] ? `FLT_20 : 32'hC2700000),
            (i == 3) ? `FLT_20K : 0, 0);
      end
      gen({ch, 8'h02, 16'h1}, `FLT_20, 0, 1);
      gen({ch, 8'h03, 16'h4}, `FLT_20, 0, 1);
      gen({ch, 8'h03, 16'h1}, 32'h41A80000, 0, 1);
      gen({ch, 8'h03, 16'h3}, `FLT_20, 32'h41980000, 1);
      gen({ch, 8'h03, 16'h2}, `FLT_20, `FLT_20, 1);
      gen({ch, 8'h01, 16'h3}, 32'hC2700000, `FLT_20, 0);
      check("src_update count", 5, upd);
      $display("test generator done");
      do_cmd(32'h036, 1, 0, 1);
      wait_title(n);
      check("idle span", 1, n >= 580 && n <= 605);
      repeat (200) @(posedge pclk);
      activity_pin <= 1;
      repeat (3) @(posedge pclk);
      activity_pin <= 0;
      wait_title(n);
      check("idle after activity", 1, n >= 590 && n <= 615);
      do_cmd(32'h036, 16, 1, 1);
      do_cmd(32'h036, 0, 1, 1);
      do_cmd(32'h136, 15, 0, 15);
      do_cmd(32'h336, 0, 0, 15);
      rdm(`OFS_SETTINGS, 32'hF0, 32'hF0);
      do_cmd(32'h136, 0, 0, 0);
      wait_title(n);
      check("idle disabled", 700, n);
      $display("test idle done");
      for (k = 0; k < 8; k++) begin
         len = (k == 7) ? 16 : $urandom_range(1, 15);
         for (i = 0; i < 16; i++)
            mem[k * 16 + i] = (i == len) ? 8'h00 : $urandom_range(1, 255);
      end
      wr(`OFS_STR_ADDR, 0);
      for (i = 0; i < 128; i++) wr(`OFS_STR_DATA, mem[i]);
      run_str(3, 0);
      run_str(7, 1);
      run_str(0, 1);
      do_cmd(32'h335, 5, 0, 0);
      do_cmd(32'h035, 8, 1, 0);
      check("no string sent", 0, byte_q.size());
      $display("test string done");
      do_cmd(32'h037, 0, 1'bx, UCODE);
      do_cmd(32'h038, 0, 1'bx, {MAJ, MIN, REL, 8'h00});
      do_cmd(32'h338, 0, 1'bx, {MAJ, MIN, REL, 8'h00});
      rdm(`OFS_RSP1, {MAJ, 8'h2E, MIN, 8'h2E}, '1);
      rdm(`OFS_RSP2, {REL, 24'h0}, '1);
      do_cmd(32'h039, 0, 1'bx, 0);
      $display("test reports done");
      print_verdict;
   end
endmodule
`default_nettype wire
